//--- gpe_pkg.sv
// package: register map, field layout and carriers for the input polarity/event slice
package gpe_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] ADDR_POLARITY_HI = 8'h1F;
	localparam logic [7:0] ADDR_POLARITY_TOP = 8'h20;
	localparam logic [7:0] ADDR_ROUTE_LO = 8'h21;
	localparam logic [7:0] ADDR_ROUTE_HI = 8'h22;
	localparam logic [7:0] ADDR_ROUTE_TOP = 8'h23;
	// ==========================================
	// field layout
	localparam int PIN_COUNT = 19;
	localparam int LO_PINS = 8;
	localparam int TOP_BITS = 3;
	localparam int SLICE_HI_BASE = 8;
	localparam int SLICE_TOP_BASE = 16;
	localparam logic [7:0] TOP_MASK = 8'h07;
	localparam logic [7:0] READ_IDLE = 8'h00;
	localparam int REG_BITS = 8;
	localparam int POL_HI_LSB = 0;
	localparam int POL_TOP_LSB = 8;
	localparam int ROUTE_LO_LSB = 0;
	// ==========================================
	// reset values
	localparam logic [18:0] POLARITY_RESET = 19'h00000;
	localparam logic [18:0] ROUTE_RESET = 19'h00000;
	localparam logic [1:0] PRIME_DONE = 2'h3;
	localparam logic [1:0] PRIME_RESET = 2'h0;
	localparam logic [1:0] PRIME_STEP = 2'h1;
	localparam logic [10:0] POL_CFG_RESET = 11'h000;
	localparam logic [18:0] PIN_IMAGE_RESET = 19'h00000;
	localparam logic [18:0] FLAG_RESET = 19'h00000;
	localparam logic STATUS_RESET = 1'b0;
	// ==========================================
	// carriers
	typedef struct packed {
		logic [10:0] polarity;
		logic [18:0] route;
	} gpe_cfg_s;
	typedef struct packed {
		logic [18:0] pulse;
		logic [18:0] level;
		logic any;
	} gpe_event_s;
endpackage

//--- gpe_input_route.sv
// top module: input polarity and event routing registers with flag and event logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - inputs 9-16 polarity in register 0x1F
// - inputs 17-19 polarity, bits 7-3 reserved
// - flag set while level equals polarity
// - inputs 1-8 event routing in 0x21
// - inputs 9-16 event routing in 0x22
// - inputs 17-19 routing, bits 7-3 reserved
// - routed activity becomes FIFO and unlock event
// - routed activity raises the event interrupt
// - routed inputs never feed input summary
// - summary when flag, enable and condition hold
module gpe_input_route #(
	parameter int NUM_PINS = 19
) (
	// clock, reset, enable
	input wire logic MCLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CE_IN,
	// register access from the serial interface
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	// neighbour configuration, same clock
	input wire logic [7:0] POLARITY_LO_IN,
	input wire logic [18:0] IRQ_ENABLE_IN,
	input wire logic IRQ_COND_IN,
	// external pins
	input wire logic [18:0] GENERAL_INPUT_PIN_IN,
	// flags and events
	output logic [18:0] PIN_IRQ_FLAG_OUT,
	output logic INPUT_IRQ_SUMMARY_OUT,
	output logic [18:0] EVENT_PULSE_OUT,
	output logic [18:0] EVENT_LEVEL_OUT,
	output logic EVENT_IRQ_OUT
);
	// ==========================================
	// elaboration check
	// every bit position is fixed by the register map, so only one width fits
	if (NUM_PINS != gpe_pkg::PIN_COUNT) begin : g_bad_pins
		$error("NUM_PINS must equal the fixed register layout");
	end

	// ==========================================
	// helper functions
	// address match, shared by all five write decodes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	// short registers keep three bits; the reserved rest reads as zero
	function automatic logic [7:0] top_view(input logic [gpe_pkg::TOP_BITS-1:0] field);
		top_view = 8'(field) & gpe_pkg::TOP_MASK;
	endfunction

	// one pin against its chosen active level
	function automatic logic level_match(input logic level, input logic polarity);
		level_match = (level == polarity);
	endfunction

	// ==========================================
	// write decode
	// bits 7..3 of a short register write are dropped, never stored
	logic wr_pol_hi;
	logic wr_pol_top;
	logic wr_route_lo;
	logic wr_route_hi;
	logic wr_route_top;
	logic [gpe_pkg::TOP_BITS-1:0] wdata_top;

	assign wr_pol_hi = REG_WR_IN && hit(REG_ADDR_IN, gpe_pkg::ADDR_POLARITY_HI);
	assign wr_pol_top = REG_WR_IN && hit(REG_ADDR_IN, gpe_pkg::ADDR_POLARITY_TOP);
	assign wr_route_lo = REG_WR_IN && hit(REG_ADDR_IN, gpe_pkg::ADDR_ROUTE_LO);
	assign wr_route_hi = REG_WR_IN && hit(REG_ADDR_IN, gpe_pkg::ADDR_ROUTE_HI);
	assign wr_route_top = REG_WR_IN && hit(REG_ADDR_IN, gpe_pkg::ADDR_ROUTE_TOP);
	assign wdata_top = REG_WDATA_IN[gpe_pkg::TOP_BITS-1:0];

	// ==========================================
	// configuration registers
	// one byte per register; a write to any other offset is simply ignored
	gpe_pkg::gpe_cfg_s cfg_reg;
	gpe_pkg::gpe_cfg_s cfg_next;

	always_comb begin
		cfg_next = cfg_reg;
		if (wr_pol_hi) begin
			cfg_next.polarity[gpe_pkg::POL_HI_LSB +: gpe_pkg::REG_BITS] = REG_WDATA_IN;
		end
		if (wr_pol_top) begin
			cfg_next.polarity[gpe_pkg::POL_TOP_LSB +: gpe_pkg::TOP_BITS] = wdata_top;
		end
		if (wr_route_lo) begin
			cfg_next.route[gpe_pkg::ROUTE_LO_LSB +: gpe_pkg::REG_BITS] = REG_WDATA_IN;
		end
		if (wr_route_hi) begin
			cfg_next.route[gpe_pkg::SLICE_HI_BASE +: gpe_pkg::REG_BITS] = REG_WDATA_IN;
		end
		if (wr_route_top) begin
			cfg_next.route[gpe_pkg::SLICE_TOP_BASE +: gpe_pkg::TOP_BITS] = wdata_top;
		end
	end

	// reset leaves inputs 9-19 active low and every input unrouted
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cfg_reg.polarity <= gpe_pkg::POL_CFG_RESET;
			cfg_reg.route <= gpe_pkg::ROUTE_RESET;
		end else if (CE_IN) begin
			cfg_reg <= cfg_next;
		end
	end

	// ==========================================
	// read back views
	// reserved bits are masked again so a stray store could never leak out
	logic [7:0] view_pol_hi;
	logic [7:0] view_pol_top;
	logic [7:0] view_route_lo;
	logic [7:0] view_route_hi;
	logic [7:0] view_route_top;

	assign view_pol_hi = cfg_reg.polarity[gpe_pkg::POL_HI_LSB +: gpe_pkg::REG_BITS];
	assign view_pol_top = top_view(cfg_reg.polarity[gpe_pkg::POL_TOP_LSB +: gpe_pkg::TOP_BITS]);
	assign view_route_lo = cfg_reg.route[gpe_pkg::ROUTE_LO_LSB +: gpe_pkg::REG_BITS];
	assign view_route_hi = cfg_reg.route[gpe_pkg::SLICE_HI_BASE +: gpe_pkg::REG_BITS];
	assign view_route_top = top_view(cfg_reg.route[gpe_pkg::SLICE_TOP_BASE +: gpe_pkg::TOP_BITS]);

	// ==========================================
	// read data register
	// holds between reads so the host may pick the byte up at its own pace
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (REG_RD_IN) begin
			// no error response: unmapped offsets read as zero
			case (REG_ADDR_IN)
				gpe_pkg::ADDR_POLARITY_HI: begin
					rdata_next = view_pol_hi;
				end
				gpe_pkg::ADDR_POLARITY_TOP: begin
					rdata_next = view_pol_top;
				end
				gpe_pkg::ADDR_ROUTE_LO: begin
					rdata_next = view_route_lo;
				end
				gpe_pkg::ADDR_ROUTE_HI: begin
					rdata_next = view_route_hi;
				end
				gpe_pkg::ADDR_ROUTE_TOP: begin
					rdata_next = view_route_top;
				end
				default: begin
					rdata_next = gpe_pkg::READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_reg <= gpe_pkg::READ_IDLE;
		end else if (CE_IN) begin
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================
	// pin synchroniser
	// two flops before any logic reads a pin; a third copy keeps the last level
	logic [18:0] sync1_reg;
	logic [18:0] sync1_next;
	logic [18:0] sync2_reg;
	logic [18:0] sync2_next;
	logic [18:0] prev_reg;
	logic [18:0] prev_next;

	always_comb begin
		sync1_next = GENERAL_INPUT_PIN_IN;
		sync2_next = sync1_reg;
		prev_next = sync2_reg;
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sync1_reg <= gpe_pkg::PIN_IMAGE_RESET;
			sync2_reg <= gpe_pkg::PIN_IMAGE_RESET;
			prev_reg <= gpe_pkg::PIN_IMAGE_RESET;
		end else if (CE_IN) begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= prev_next;
		end
	end

	// ==========================================
	// start-up guard
	// the reset image of the pins is no real level, so no edge counts until
	// three enabled clocks refill the pipeline; costs three blind cycles
	logic [1:0] prime_reg;
	logic [1:0] prime_next;
	logic primed;

	always_comb begin
		prime_next = prime_reg;
		if (prime_reg != gpe_pkg::PRIME_DONE) begin
			prime_next = prime_reg + gpe_pkg::PRIME_STEP;
		end
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			prime_reg <= gpe_pkg::PRIME_RESET;
		end else if (CE_IN) begin
			prime_reg <= prime_next;
		end
	end

	assign primed = (prime_reg == gpe_pkg::PRIME_DONE);

	// ==========================================
	// per-pin compare and activity
	// both edges of a synchronised pin count as activity
	logic [18:0] polarity_all;
	logic [18:0] flag_now;
	logic [18:0] activity;
	logic [18:0] routed_act;
	logic [18:0] summary_src;

	// inputs 1 to 8 take their polarity from the neighbouring register
	assign polarity_all = {cfg_reg.polarity, POLARITY_LO_IN};

	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		assign flag_now[i] = level_match(sync2_reg[i], polarity_all[i]);
		assign activity[i] = (sync2_reg[i] != prev_reg[i]) && primed;
		assign routed_act[i] = activity[i] && cfg_reg.route[i];
		assign summary_src[i] = flag_now[i] && IRQ_ENABLE_IN[i] && !cfg_reg.route[i];
	end

	// ==========================================
	// pin flags
	// level flags, not sticky: no clear exists, so no set/clear race
	logic [18:0] flag_reg;
	logic [18:0] flag_next;

	always_comb begin
		flag_next = flag_now;
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			flag_reg <= gpe_pkg::FLAG_RESET;
		end else if (CE_IN) begin
			flag_reg <= flag_next;
		end
	end

	// ==========================================
	// summary interrupt
	// routed pins are masked before the OR; condition gates it last
	logic summary_reg;
	logic summary_next;

	always_comb begin
		summary_next = IRQ_COND_IN && (|summary_src);
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			summary_reg <= gpe_pkg::STATUS_RESET;
		end else if (CE_IN) begin
			summary_reg <= summary_next;
		end
	end

	// ==========================================
	// events toward the fifo and unlock matcher
	// the pulse lasts one enabled cycle; the level rides along for the entry
	gpe_pkg::gpe_event_s evt_reg;
	gpe_pkg::gpe_event_s evt_next;

	always_comb begin
		evt_next.pulse = routed_act;
		evt_next.level = sync2_reg;
		evt_next.any = |routed_act;
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			evt_reg <= '0;
		end else if (CE_IN) begin
			evt_reg <= evt_next;
		end
	end

	// ==========================================
	// outputs, all from flops
	assign REG_RDATA_OUT = rdata_reg;
	assign PIN_IRQ_FLAG_OUT = flag_reg;
	assign INPUT_IRQ_SUMMARY_OUT = summary_reg;
	assign EVENT_PULSE_OUT = evt_reg.pulse;
	assign EVENT_LEVEL_OUT = evt_reg.level;
	assign EVENT_IRQ_OUT = evt_reg.any;
endmodule // gpe_input_route
`default_nettype wire

//--- gpe_input_route_sva.sv
// checker for the polarity and event slice
`timescale 1ns/1ps
`default_nettype none
module gpe_input_route_sva (
	// clock, reset
	input wire logic MCLK_IN,
	input wire logic ARST_N_IN,
	// register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	// pins and outputs
	input wire logic [7:0] POLARITY_LO_IN,
	input wire logic [18:0] IRQ_ENABLE_IN,
	input wire logic IRQ_COND_IN,
	input wire logic [18:0] GENERAL_INPUT_PIN_IN,
	input wire logic [18:0] PIN_IRQ_FLAG_OUT,
	input wire logic INPUT_IRQ_SUMMARY_OUT,
	input wire logic [18:0] EVENT_PULSE_OUT,
	input wire logic [18:0] EVENT_LEVEL_OUT,
	input wire logic EVENT_IRQ_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	// =====
	// assertions
	// five clean edges so the synchroniser no longer holds the reset image
	sequence settled_s;
		ARST_N_IN [*5] ##0 $stable(POLARITY_LO_IN);
	endsequence
	chk_rd_idle: assert property (REG_RD_IN && !(REG_ADDR_IN inside {[8'h1F:8'h23]}) |=>
		REG_RDATA_OUT == 8'h00) else $error("unmapped read");
	chk_rsvd_zero: assert property (REG_RD_IN && REG_ADDR_IN inside {8'h20, 8'h23} |=>
		REG_RDATA_OUT[7:3] == 5'h00) else $error("reserved bits");
	chk_rd_hold: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("rdata moved");
	chk_evt_or: assert property (EVENT_IRQ_OUT == (|EVENT_PULSE_OUT)) else $error("event irq");
	chk_evt_cause: assert property ((EVENT_PULSE_OUT & ~($past(GENERAL_INPUT_PIN_IN, 3) ^
		$past(GENERAL_INPUT_PIN_IN, 4))) == 19'h00000) else $error("pulse without change");
	chk_level_pair: assert property ((EVENT_PULSE_OUT & (EVENT_LEVEL_OUT ^
		$past(GENERAL_INPUT_PIN_IN, 3))) == 19'h00000) else $error("event level");
	chk_flag_lo: assert property (settled_s |-> PIN_IRQ_FLAG_OUT[7:0] ==
		~($past(GENERAL_INPUT_PIN_IN[7:0], 3) ^ POLARITY_LO_IN)) else $error("flag");
	chk_sum_gate: assert property (!IRQ_COND_IN || IRQ_ENABLE_IN == 19'h00000 |=>
		!INPUT_IRQ_SUMMARY_OUT) else $error("summary");
endmodule // gpe_input_route_sva
`default_nettype wire

//--- gpe_host_model.sv
// host model: register reads and writes
`timescale 1ns/1ps
`default_nettype none
module gpe_host_model (
	// clock
	input wire logic clk_in,
	// register port
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in
);
	initial {addr_out, wr_out, rd_out, wdata_out} = 18'h00000;
	// bus inverted after use so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, inout logic [7:0] d);
		@(posedge clk_in) #1;
		{addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
		@(posedge clk_in) #1;
		{addr_out, wdata_out, wr_out, rd_out} = {~a, ~d, 2'b00};
		d = w ? d : rdata_in;
	endtask
endmodule // gpe_host_model
`default_nettype wire

//--- gpe_input_route_tb_top.sv
// testbench for the polarity and event slice
`timescale 1ns/1ps
`default_nettype none
module gpe_input_route_tb_top;
	logic MCLK_IN = 1'b0;
	logic ARST_N_IN = 1'b0;
	logic CE_IN = 1'b1;
	logic REG_WR_IN, REG_RD_IN, IRQ_COND_IN, INPUT_IRQ_SUMMARY_OUT, EVENT_IRQ_OUT;
	logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, POLARITY_LO_IN, d, w;
	logic [18:0] IRQ_ENABLE_IN, GENERAL_INPUT_PIN_IN, PIN_IRQ_FLAG_OUT, EVENT_PULSE_OUT;
	logic [18:0] EVENT_LEVEL_OUT, q, t, p, r;
	logic [7:0] wv [30:36];
	int bad_count = 0;
	int compares = 0;
	always #5 MCLK_IN = ~MCLK_IN;
	gpe_host_model gpe_host_model_i (.clk_in(MCLK_IN), .addr_out(REG_ADDR_IN), .wr_out(REG_WR_IN),
		.rd_out(REG_RD_IN), .wdata_out(REG_WDATA_IN), .rdata_in(REG_RDATA_OUT));
	gpe_input_route gpe_input_route_i (.*);
	task automatic chk(input logic [18:0] g, input logic [18:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask
	task automatic test_done;
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// unmapped offsets read back zero
	function automatic logic [7:0] rmask(input int a);
		return a inside {32, 35} ? gpe_pkg::TOP_MASK : a inside {[31:35]} ? 8'hFF : 8'h00;
	endfunction
	initial begin
		#100000;
		bad_count++;
		test_done;
	end
	initial begin
		{GENERAL_INPUT_PIN_IN, IRQ_ENABLE_IN, IRQ_COND_IN, POLARITY_LO_IN} = '0;
		void'($urandom(70290));
		repeat (8) @(posedge MCLK_IN);
		#1 ARST_N_IN = 1'b1;
		for (int a = 30; a <= 36; a++) begin
			gpe_host_model_i.xfer(1'b0, 8'(a), d);
			chk(19'(d), 19'h00000);
		end
		// first pass all ones: reserved bits and every input routed
		for (int i = 0; i < 20; i++) begin
			for (int a = 30; a <= 36; a++) begin
				w = (i == 0) ? 8'hFF : 8'($urandom);
				wv[a] = w & rmask(a);
				gpe_host_model_i.xfer(1'b1, 8'(a), w);
				gpe_host_model_i.xfer(1'b0, 8'(a), d);
				chk(19'(d), 19'(wv[a]));
			end
			q = GENERAL_INPUT_PIN_IN;
			{GENERAL_INPUT_PIN_IN, IRQ_ENABLE_IN, IRQ_COND_IN, POLARITY_LO_IN} = 47'({$urandom, $urandom});
			p = {wv[32][2:0], wv[31], POLARITY_LO_IN};
			r = {wv[35][2:0], wv[34], wv[33]};
			t = (GENERAL_INPUT_PIN_IN ^ q) & r;
			repeat (3) @(posedge MCLK_IN);
			#1 chk(EVENT_PULSE_OUT, t);
			chk(19'(EVENT_IRQ_OUT), 19'(|t));
			chk(EVENT_LEVEL_OUT, GENERAL_INPUT_PIN_IN);
			t = ~(GENERAL_INPUT_PIN_IN ^ p);
			repeat (2) @(posedge MCLK_IN);
			#1 chk(PIN_IRQ_FLAG_OUT, t);
			chk(19'(INPUT_IRQ_SUMMARY_OUT), 19'(IRQ_COND_IN & |(t & IRQ_ENABLE_IN & ~r)));
		end
		test_done;
	end
endmodule // gpe_input_route_tb_top
bind gpe_input_route gpe_input_route_sva gpe_input_route_sva_i (.*);
`default_nettype wire
